// *** logic/pad_pkg.sv ***
package pad_pkg;
   // Datapath sizes.
   localparam int PAD_DW = 16;
   localparam int PAD_CW = 16;
   localparam int PAD_PW = 32;
   localparam int PAD_AW = 40;
   localparam int PAD_SW = 44;
   localparam int PAD_TAPS = 8;
   localparam int PAD_PHASES = 16;
   localparam int PAD_TAPW = 3;
   localparam int PAD_PHW = 4;
   localparam int PAD_STW = 5;
   localparam int PAD_CAW = 7;
   localparam int PAD_SHW = 5;
   localparam int PAD_BAW = 5;
   // Register byte offsets.
   localparam logic [4:0] PAD_OFS_STEP = 5'h00;
   localparam logic [4:0] PAD_OFS_SCALE = 5'h04;
   localparam logic [4:0] PAD_OFS_STATUS = 5'h08;
   localparam logic [4:0] PAD_OFS_MASK = 5'h0c;
   localparam logic [4:0] PAD_OFS_CADDR = 5'h10;
   localparam logic [4:0] PAD_OFS_CDATA = 5'h14;
   localparam logic [4:0] PAD_OFS_PHASE = 5'h18;
   // Field positions.
   localparam int PAD_SC_MAC_LSB = 0;
   localparam int PAD_SC_FIN_LSB = 8;
   localparam int PAD_PH_CUR_LSB = 0;
   localparam int PAD_PH_STEP_LSB = 8;
   localparam int PAD_ST_OUT = 0;
   localparam int PAD_ST_STEPERR = 1;
   localparam int PAD_NSTAT = 2;
   // Reset values and limits.
   localparam logic [4:0] PAD_STEP_MAX = 5'h10;
   localparam logic [4:0] PAD_STEP_RST = 5'h01;
   localparam logic [4:0] PAD_SHIFT_RST = 5'h00;
   localparam logic [5:0] PAD_PH_WRAP = 6'h10;

   typedef struct packed {
      logic [PAD_DW-1:0] data;
      logic [PAD_STW-1:0] rate;
   } pad_out_t;

   typedef struct packed {
      logic [PAD_SHW-1:0] mac;
      logic [PAD_SHW-1:0] fin;
   } pad_scale_t;
endpackage : pad_pkg

// *** logic/pad_decimator.sv ***
// Functional notes
// - One polyphase FIR path; coefficient set changes on every input sample unless the step equals the polyphase count.
// - Coefficients come from a lookup memory, selected per current polyphase.
// - A phase accumulator selects the polyphase; its step sets the ratio.
// - Overflow indication fires exactly when a decimated output is produced.
// - Step never exceeds polyphase count; ratio is polyphases over step.
// - Each tap's product feeds its own accumulator until rollover.
// - On rollover all tap accumulators are added into one output sample.
// - Tap accumulators clear in the same cycle the output is formed.
// - Memory holds one prototype filter shared by every ratio.
// - Phase increment is writable at run time over the register bus.
// - Polyphases accumulated per output follow the current ratio.
// - Programmable scaling on accumulator outputs and final adder output.
// - Each output carries the step in effect when it was produced.
`timescale 1ns/1ns
`default_nettype none
module pad_decimator
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Register bus slave.
   input wire logic [pad_pkg::PAD_BAW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Input sample stream.
   input wire logic in_valid,
   input wire logic [pad_pkg::PAD_DW-1:0] in_data,
   // Decimated output stream.
   output logic out_valid,
   output pad_pkg::pad_out_t out_sample,
   output logic phase_wrap,
   // Interrupt.
   output logic irq
);
   import pad_pkg::*;

   logic ack_r;
   logic wr_go;
   logic [4:0] step_pend_r;
   logic [4:0] step_act_r;
   pad_scale_t scale_pend_r;
   pad_scale_t scale_act_r;
   logic [PAD_NSTAT-1:0] status_r;
   logic [PAD_NSTAT-1:0] mask_r;
   logic [PAD_CAW-1:0] caddr_r;
   logic [PAD_CW-1:0] coef_mem [0:PAD_TAPS*PAD_PHASES-1];
   logic [PAD_PHW-1:0] ph_r;
   logic [5:0] ph_sum;
   logic wrap;
   logic [PAD_DW-1:0] dl_r [0:PAD_TAPS-2];
   logic [PAD_DW-1:0] x [0:PAD_TAPS-1];
   logic [PAD_AW-1:0] acc_r [0:PAD_TAPS-1];
   logic [PAD_AW-1:0] acc_sum [0:PAD_TAPS-1];
   logic [PAD_AW-1:0] acc_sc [0:PAD_TAPS-1];
   logic [PAD_SW-1:0] add_all;
   logic [PAD_SW-1:0] fin_sc;
   logic step_bad;
   logic [31:0] rd_nxt;

   // Every access costs one wait cycle, so read data is always registered.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_go = avs_write & ack_r;
   assign step_bad = (avs_writedata[4:0] == 5'h00) || (avs_writedata[4:0] > PAD_STEP_MAX) ||
                     (avs_writedata[31:5] != 27'h0000000);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   always_comb begin
      rd_nxt = 32'h00000000;
      if (avs_address == PAD_OFS_STEP) begin
         rd_nxt[4:0] = step_pend_r;
      end else if (avs_address == PAD_OFS_SCALE) begin
         rd_nxt[PAD_SC_MAC_LSB +: PAD_SHW] = scale_pend_r.mac;
         rd_nxt[PAD_SC_FIN_LSB +: PAD_SHW] = scale_pend_r.fin;
      end else if (avs_address == PAD_OFS_STATUS) begin
         rd_nxt[PAD_NSTAT-1:0] = status_r;
      end else if (avs_address == PAD_OFS_MASK) begin
         rd_nxt[PAD_NSTAT-1:0] = mask_r;
      end else if (avs_address == PAD_OFS_CADDR) begin
         rd_nxt[PAD_CAW-1:0] = caddr_r;
      end else if (avs_address == PAD_OFS_CDATA) begin
         rd_nxt[PAD_CW-1:0] = coef_mem[caddr_r];
      end else if (avs_address == PAD_OFS_PHASE) begin
         rd_nxt[PAD_PH_CUR_LSB +: PAD_PHW] = ph_r;
         rd_nxt[PAD_PH_STEP_LSB +: PAD_STW] = step_act_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_r) begin
         avs_readdata <= rd_nxt;
      end
   end

   // Out-of-range steps are clamped so the ratio can never drop below one.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         step_pend_r <= PAD_STEP_RST;
      end else if (wr_go && avs_address == PAD_OFS_STEP) begin
         step_pend_r <= step_bad ? PAD_STEP_MAX : avs_writedata[4:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         scale_pend_r <= '{mac: PAD_SHIFT_RST, fin: PAD_SHIFT_RST};
      end else if (wr_go && avs_address == PAD_OFS_SCALE) begin
         scale_pend_r.mac <= avs_writedata[PAD_SC_MAC_LSB +: PAD_SHW];
         scale_pend_r.fin <= avs_writedata[PAD_SC_FIN_LSB +: PAD_SHW];
      end
   end

   // Settings move to the live copy only when an output closes.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         step_act_r <= PAD_STEP_RST;
         scale_act_r <= '{mac: PAD_SHIFT_RST, fin: PAD_SHIFT_RST};
      end else if (in_valid && wrap) begin
         step_act_r <= step_pend_r;
         scale_act_r <= scale_pend_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mask_r <= '0;
      end else if (wr_go && avs_address == PAD_OFS_MASK) begin
         mask_r <= avs_writedata[PAD_NSTAT-1:0];
      end
   end

   // Hardware set wins over a write-one clear in the same cycle.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status_r <= '0;
      end else begin
         status_r[PAD_ST_OUT] <= (in_valid && wrap) ||
            (status_r[PAD_ST_OUT] && !(wr_go && avs_address == PAD_OFS_STATUS &&
             avs_writedata[PAD_ST_OUT]));
         status_r[PAD_ST_STEPERR] <= (wr_go && avs_address == PAD_OFS_STEP && step_bad) ||
            (status_r[PAD_ST_STEPERR] && !(wr_go && avs_address == PAD_OFS_STATUS &&
             avs_writedata[PAD_ST_STEPERR]));
      end
   end

   assign irq = |(status_r & mask_r);

   // Coefficients are written through an auto-incrementing address. Rewriting them
   // while samples flow is allowed but mixes old and new taps in one output.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         caddr_r <= '0;
      end else if (wr_go && avs_address == PAD_OFS_CADDR) begin
         caddr_r <= avs_writedata[PAD_CAW-1:0];
      end else if (wr_go && avs_address == PAD_OFS_CDATA) begin
         caddr_r <= caddr_r + 7'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_go && avs_address == PAD_OFS_CDATA) begin
         coef_mem[caddr_r] <= avs_writedata[PAD_CW-1:0];
      end
   end

   // Phase accumulator, modulo the polyphase count.
   assign ph_sum = {2'b00, ph_r} + {1'b0, step_act_r};
   assign wrap = ph_sum >= PAD_PH_WRAP;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ph_r <= '0;
      end else if (in_valid) begin
         ph_r <= wrap ? 4'(ph_sum - PAD_PH_WRAP) : ph_sum[3:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < PAD_TAPS-1; i++) begin
            dl_r[i] <= '0;
         end
      end else if (in_valid) begin
         dl_r[0] <= in_data;
         for (int i = 1; i < PAD_TAPS-1; i++) begin
            dl_r[i] <= dl_r[i-1];
         end
      end
   end

   assign x[0] = in_data;

   genvar g;
   generate
      for (g = 0; g < PAD_TAPS; g++) begin : g_tap
         localparam logic [PAD_TAPW-1:0] TI = PAD_TAPW'(g);
         logic signed [PAD_PW-1:0] prod;
         if (g > 0) begin : g_dl
            assign x[g] = dl_r[g-1];
         end
         // Tap g of polyphase p is prototype coefficient g*N + p.
         assign prod = $signed(x[g]) * $signed(coef_mem[{TI, ph_r}]);
         assign acc_sum[g] = acc_r[g] + {{(PAD_AW-PAD_PW){prod[PAD_PW-1]}}, prod};
         assign acc_sc[g] = PAD_AW'($signed(acc_sum[g]) >>> scale_act_r.mac);
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               acc_r[g] <= '0;
            end else if (in_valid) begin
               acc_r[g] <= wrap ? '0 : acc_sum[g];
            end
         end
      end
   endgenerate

   always_comb begin
      add_all = '0;
      for (int i = 0; i < PAD_TAPS; i++) begin
         add_all = add_all + {{(PAD_SW-PAD_AW){acc_sc[i][PAD_AW-1]}}, acc_sc[i]};
      end
   end

   // The final shift keeps the wanted bits in the low word; no saturation is done.
   assign fin_sc = PAD_SW'($signed(add_all) >>> scale_act_r.fin);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         out_valid <= 1'b0;
         phase_wrap <= 1'b0;
         out_sample <= '0;
      end else begin
         out_valid <= in_valid && wrap;
         phase_wrap <= in_valid && wrap;
         if (in_valid && wrap) begin
            out_sample.data <= fin_sc[PAD_DW-1:0];
            out_sample.rate <= step_act_r;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_wrap_causes_out: assert property (out_valid |-> $past(in_valid) && $past(wrap))
      else $error("Output appeared without a phase wrap.");
   a_wrap_gives_out: assert property (in_valid && wrap |=> out_valid && phase_wrap)
      else $error("Phase wrap did not produce an output.");
   a_acc_cleared: assert property (out_valid |-> acc_r[0] == '0 && acc_r[PAD_TAPS-1] == '0)
      else $error("Accumulators not cleared at output.");
   a_rate_tagged: assert property (out_valid |-> out_sample.rate == $past(step_act_r))
      else $error("Output rate tag differs from active step.");
   a_step_bounded: assert property (step_act_r != 5'h00 && step_act_r <= PAD_STEP_MAX)
      else $error("Active step out of range.");
   a_setting_held: assert property (!($past(in_valid) && $past(wrap)) |->
      $stable(step_act_r) && $stable(scale_act_r))
      else $error("Setting changed away from an output boundary.");
   a_phase_steps: assert property (in_valid && !wrap |=> ph_r == 4'($past(ph_sum)))
      else $error("Phase did not advance by the step.");
   a_sum_emitted: assert property (in_valid && wrap |=> out_sample.data == PAD_DW'($past(fin_sc)))
      else $error("Output is not the scaled sum of taps.");
   a_acc_builds: assert property (in_valid && !wrap |=> acc_r[0] == $past(acc_sum[0]))
      else $error("Tap accumulator did not collect the product.");
   a_status_set: assert property (out_valid |-> status_r[PAD_ST_OUT])
      else $error("Output event not recorded in status.");
   // The bus answers after exactly one wait cycle, so the acknowledge must drop again.
   a_bus_one_wait: assert property ((avs_read || avs_write) && !ack_r |=> ack_r)
      else $error("Bus request was not acknowledged after one wait.");
   a_bus_ack_drops: assert property (ack_r |=> !ack_r)
      else $error("Bus acknowledge lasted more than one cycle.");
   a_rdata_held: assert property (!(avs_read && !ack_r) |=> $stable(avs_readdata))
      else $error("Read data changed without a new read.");
   a_step_pend_held: assert property (!(wr_go && avs_address == PAD_OFS_STEP) |=> $stable(step_pend_r))
      else $error("Pending step changed without a write.");
   a_step_clamped: assert property (wr_go && avs_address == PAD_OFS_STEP && step_bad |=>
      step_pend_r == PAD_STEP_MAX && status_r[PAD_ST_STEPERR])
      else $error("Bad step write was not clamped and flagged.");
   a_set_recorded: assert property (in_valid && wrap |=> status_r[PAD_ST_OUT])
      else $error("Output event lost to a status clear.");
   a_phase_modulo: assert property (in_valid |=> ph_r == 4'($past(ph_r) + $past(step_act_r)))
      else $error("Phase did not advance modulo the polyphase count.");
   a_phase_idle: assert property (!in_valid |=> $stable(ph_r))
      else $error("Phase moved without an input sample.");
   a_acc_idle: assert property (!in_valid |=> $stable(acc_r[0]) && $stable(acc_r[PAD_TAPS-1]))
      else $error("Tap accumulator moved without an input sample.");
   a_out_held: assert property (!out_valid |-> $stable(out_sample))
      else $error("Output sample changed without an output strobe.");
   a_settings_follow: assert property (in_valid && wrap |=> step_act_r == $past(step_pend_r) &&
      scale_act_r == $past(scale_pend_r))
      else $error("Pending settings not applied at the output boundary.");
endmodule : pad_decimator
`default_nettype wire

// *** tb/pad_stream_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pad_stream_model
(
   // Clock.
   input wire logic clk_sys,
   // Sample source.
   output logic in_valid,
   output logic [pad_pkg::PAD_DW-1:0] in_data,
   // Sample sink.
   input wire logic out_valid,
   input wire pad_pkg::pad_out_t out_sample,
   input wire logic phase_wrap
);
   import pad_pkg::*;
   int nsent = 0;
   int wrap_bad = 0;
   int q_at[$];
   pad_out_t q_out[$];

   initial begin
      in_valid = 1'b0;
      in_data = 16'h0000;
   end

   // Samples go out one per valid cycle, with gap idle cycles after each.
   // Idle data shows the inverse of the last sample so a stale value is never mistaken for a real one.
   task automatic send(input logic [PAD_DW-1:0] val, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         in_valid <= 1'b1;
         in_data <= val;
         repeat (gap) begin
            @(posedge clk_sys);
            in_valid <= 1'b0;
            in_data <= ~val;
         end
      end
      @(posedge clk_sys);
      in_valid <= 1'b0;
      in_data <= ~val;
   endtask : send

   // Each output is logged with the count of samples taken before it.
   always @(posedge clk_sys) begin
      if (in_valid === 1'b1) begin
         nsent <= nsent + 1;
      end
      if (out_valid !== phase_wrap) begin
         wrap_bad <= wrap_bad + 1;
      end
      if (out_valid === 1'b1) begin
         q_at.push_back(nsent);
         q_out.push_back(out_sample);
      end
   end
endmodule : pad_stream_model
`default_nettype wire

// *** tb/pad_decimator_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module pad_decimator_tb;
   import pad_pkg::*;
   logic clk_sys;
   logic srst;
   logic [PAD_BAW-1:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic in_valid, out_valid, phase_wrap, irq;
   logic [PAD_DW-1:0] in_data;
   pad_out_t out_sample;
   int errors = 0;
   int checks = 0;
   int ns = 0;

   pad_decimator i_pad_decimator (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
      .in_data(in_data), .out_valid(out_valid), .out_sample(out_sample),
      .phase_wrap(phase_wrap), .irq(irq));
   pad_stream_model i_pad_stream_model (.clk_sys(clk_sys), .in_valid(in_valid), .in_data(in_data),
      .out_valid(out_valid), .out_sample(out_sample), .phase_wrap(phase_wrap));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // The request stands until a rising edge sees waitrequest low; data is taken and released there.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [4:0] a, input logic [31:0] ex, input string nm);
      bus(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
   endtask : rdchk

   // Every sample is -20, so each tap sum is -20 times the coefficient sum s of the visited phases.
   task automatic batch(input int n, input int gap, input int s, input logic [4:0] rate,
                        input int mac, input int fin, input bit dchk);
      int e;
      i_pad_stream_model.send(16'hffec, n, gap);
      ns += n;
      repeat (3) @(posedge clk_sys);
      e = ((-20 * s) >>> mac) * 8;
      e = e >>> fin;
      `CHK("outputs", 1, i_pad_stream_model.q_at.size())
      if (i_pad_stream_model.q_at.size() == 1) begin
         `CHK("out_at", ns, i_pad_stream_model.q_at[0])
         `CHK("rate", rate, i_pad_stream_model.q_out[0].rate)
         if (dchk) `CHK("data", e[15:0], i_pad_stream_model.q_out[0].data)
      end
      i_pad_stream_model.q_at.delete();
      i_pad_stream_model.q_out.delete();
      $display("test batch of %0d samples done", n);
   endtask : batch

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      $display("test watchdog expired");
      print_verdict();
   end

   initial begin
      srst = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rdchk(PAD_OFS_STEP, 32'h1, "step reset");
      rdchk(PAD_OFS_SCALE, 32'h0, "scale reset");
      rdchk(PAD_OFS_MASK, 32'h0, "mask reset");
      rdchk(PAD_OFS_PHASE, 32'h100, "phase reset");
      rdchk(5'h1c, 32'h0, "unmapped");
      $display("test register reset done");
      // Coefficient depends on phase only, so each ratio gives a distinct sum.
      bus(1'b1, PAD_OFS_CADDR, 32'h0);
      for (int i = 0; i < 128; i++) bus(1'b1, PAD_OFS_CDATA, 32'(i % 16 + 1));
      bus(1'b1, PAD_OFS_CADDR, 32'h23);
      rdchk(PAD_OFS_CDATA, 32'h4, "coef readback");
      bus(1'b1, PAD_OFS_STEP, 32'h10);
      batch(16, 1, 136, 5'h01, 0, 0, 1'b0);
      `CHK("irq masked", 1'b0, irq)
      rdchk(PAD_OFS_STATUS, 32'h1, "status out");
      bus(1'b1, PAD_OFS_MASK, 32'h1);
      @(negedge clk_sys);
      `CHK("irq on", 1'b1, irq)
      bus(1'b1, PAD_OFS_STATUS, 32'h1);
      @(negedge clk_sys);
      `CHK("irq cleared", 1'b0, irq)
      $display("test interrupt done");
      batch(1, 0, 1, 5'h10, 0, 0, 1'b1);
      batch(1, 1, 1, 5'h10, 0, 0, 1'b1);
      bus(1'b1, PAD_OFS_STEP, 32'h4);
      batch(1, 0, 1, 5'h10, 0, 0, 1'b1);
      batch(4, 1, 28, 5'h04, 0, 0, 1'b1);
      bus(1'b1, PAD_OFS_SCALE, 32'h201);
      bus(1'b1, PAD_OFS_STEP, 32'h3);
      batch(4, 0, 28, 5'h04, 0, 0, 1'b1);
      batch(6, 1, 51, 5'h03, 1, 2, 1'b1);
      batch(5, 0, 45, 5'h03, 1, 2, 1'b1);
      rdchk(PAD_OFS_PHASE, 32'h301, "phase now");
      bus(1'b1, PAD_OFS_STEP, 32'h0);
      rdchk(PAD_OFS_STATUS, 32'h3, "step error");
      `CHK("wrap pulse", 0, i_pad_stream_model.wrap_bad)
      $display("test step error done");
      print_verdict();
   end
endmodule : pad_decimator_tb
`default_nettype wire
